// ===== logic/sesl_event_status.sv
// Standard event status register, enable mask and event summary bit
// Overview of operation
// - Mask write stores 8-bit value 0..255; mask resets to zero.
// - Summary bit 5 of status byte is OR of flags AND mask.
// - Flag bits: 5 cmd, 4 exec, 3 device, 2 query, 0 done; others zero.
// - Mask query returns stored mask unless a flag query comes with it, and changes nothing.
// - Flag query returns current flags then clears them all.
// - Clear-status clears flags and status byte, keeps masks.
// - Clear-status also empties the error queue.
// - Clear-status forces operation-complete tracking to idle.
// - Error code class 1xx sets command error bit.
// - Error code class 2xx sets execution error bit.
// - Error code class 3xx sets device-dependent error bit.
// - Current or voltage error while its questionable bit rises sets device error.
// - Error code class 4xx sets query error bit.
// - Completion command clears bit 0; set once all pending work finished.
`include "sesl_map.svh"
`default_nettype none
module sesl_event_status (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  // Commands from the parser
  input  wire sesl_pkg::sesl_cmd_s cmd_i,
  // Error reports
  input  wire sesl_pkg::sesl_err_s err_i,
  input  wire logic                err_pop_i,
  // Output-stage faults
  input  wire logic                curr_err_i,
  input  wire logic                volt_err_i,
  input  wire logic                ques_curr_i,
  input  wire logic                ques_volt_i,
  // Completion state of pending work
  input  wire logic                ops_idle_i,
  // Answers and status
  output sesl_pkg::sesl_resp_s     resp_o,
  output logic [7:0]               flags_o,
  output logic [7:0]               mask_o,
  output logic                     esb_o,
  output logic                     clear_stb_o,
  output logic                     err_empty_o,
  output logic [9:0]               err_head_o,
  output logic                     opc_armed_o
);
  import sesl_pkg::*;

  function automatic logic [7:0] bit_of(input logic [2:0] pos);
    bit_of = 8'h01 << pos;
  endfunction : bit_of

  function automatic logic class_is(input sesl_err_s e, input logic [3:0] c);
    class_is = e.valid && (e.err_class == c);
  endfunction : class_is

  localparam logic [7:0] FLAGS_RST = `SESL_FLAGS_RESET;

  logic [7:0]       flags;
  logic [7:0]       mask;
  logic             flag_cme;
  logic             flag_exe;
  logic             flag_dde;
  logic             flag_que;
  logic             flag_opc;
  sesl_opc_e        opc_state;
  sesl_opc_e        next_opc_state;
  sesl_resp_s       resp;
  logic             ques_curr_d;
  logic             ques_volt_d;

  // Command strobes named once; the queue flush reads cmd_i.clear_status directly
  wire       mask_wr_w     = cmd_i.mask_wr;
  wire [7:0] mask_data_w   = cmd_i.mask_data;
  wire       mask_query_w  = cmd_i.mask_query;
  wire       flags_query_w = cmd_i.flags_query;
  wire       clear_w       = cmd_i.clear_status;
  wire       opc_cmd_w     = cmd_i.opc_cmd;

  // Error class decode
  wire       cls_cmd_w     = class_is(err_i, `SESL_CLASS_CMD);
  wire       cls_exe_w     = class_is(err_i, `SESL_CLASS_EXE);
  wire       cls_dev_w     = class_is(err_i, `SESL_CLASS_DEV);
  wire       cls_query_w   = class_is(err_i, `SESL_CLASS_QUERY);

  // Questionable bit rising together with its error marks a new device fault
  wire       ques_curr_rise_w = ques_curr_i && !ques_curr_d;
  wire       ques_volt_rise_w = ques_volt_i && !ques_volt_d;
  wire       ddf_curr_w       = curr_err_i && ques_curr_rise_w;
  wire       ddf_volt_w       = volt_err_i && ques_volt_rise_w;
  wire       ddf_w            = ddf_curr_w || ddf_volt_w;

  // Completion tracking
  wire       opc_armed_w   = (opc_state == SESL_OPC_ARMED);
  wire       opc_done_w    = opc_armed_w && ops_idle_i;

  // One set term per event bit
  wire [7:0] set_cme_w = cls_cmd_w   ? bit_of(`SESL_BIT_CME) : 8'h00;
  wire [7:0] set_exe_w = cls_exe_w   ? bit_of(`SESL_BIT_EXE) : 8'h00;
  wire [7:0] set_dde_w = (cls_dev_w || ddf_w) ? bit_of(`SESL_BIT_DDE) : 8'h00;
  wire [7:0] set_que_w = cls_query_w ? bit_of(`SESL_BIT_QUE) : 8'h00;
  wire [7:0] set_opc_w = opc_done_w  ? bit_of(`SESL_BIT_OPC) : 8'h00;
  wire [7:0] set_w     = set_cme_w | set_exe_w | set_dde_w | set_que_w | set_opc_w;

  // A new event in the clearing cycle survives the clear
  wire       clr_all_w  = flags_query_w || clear_w;
  wire [7:0] clr_opc_w  = opc_cmd_w ? bit_of(`SESL_BIT_OPC) : 8'h00;
  wire [7:0] kept_w     = (clr_all_w ? 8'h00 : flags) & ~clr_opc_w;
  wire [7:0] next_flags = (kept_w | set_w) & `SESL_USED_MASK;

  // Mask changes only on a write; queries leave it alone
  wire [7:0] next_mask  = mask_wr_w ? mask_data_w : mask;

  // Query answers: flag query sees the value before this cycle's clear
  // Both queries at once: the flag answer wins
  wire       resp_valid_w = mask_query_w || flags_query_w;
  wire [7:0] resp_data_w  = flags_query_w ? flags : mask;
  assign resp = {resp_valid_w, resp_data_w};

  always_comb begin
    next_opc_state = opc_state;
    if (clear_w) begin
      next_opc_state = SESL_OPC_IDLE;
    end else if (opc_cmd_w) begin
      next_opc_state = SESL_OPC_ARMED;
    end else begin
      unique case (opc_state)
        SESL_OPC_IDLE:  next_opc_state = SESL_OPC_IDLE;
        SESL_OPC_ARMED: if (ops_idle_i) next_opc_state = SESL_OPC_IDLE;
        default:        next_opc_state = SESL_OPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask <= `SESL_MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // One flop per event, so each sticky bit can be traced on its own
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_cme <= FLAGS_RST[`SESL_BIT_CME];
    end else begin
      flag_cme <= next_flags[`SESL_BIT_CME];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_exe <= FLAGS_RST[`SESL_BIT_EXE];
    end else begin
      flag_exe <= next_flags[`SESL_BIT_EXE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_dde <= FLAGS_RST[`SESL_BIT_DDE];
    end else begin
      flag_dde <= next_flags[`SESL_BIT_DDE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_que <= FLAGS_RST[`SESL_BIT_QUE];
    end else begin
      flag_que <= next_flags[`SESL_BIT_QUE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_opc <= FLAGS_RST[`SESL_BIT_OPC];
    end else begin
      flag_opc <= next_flags[`SESL_BIT_OPC];
    end
  end

  // Unused positions stay tied low rather than stored
  always_comb begin
    flags                = 8'h00;
    flags[`SESL_BIT_CME] = flag_cme;
    flags[`SESL_BIT_EXE] = flag_exe;
    flags[`SESL_BIT_DDE] = flag_dde;
    flags[`SESL_BIT_QUE] = flag_que;
    flags[`SESL_BIT_OPC] = flag_opc;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opc_state <= SESL_OPC_IDLE;
    end else begin
      opc_state <= next_opc_state;
    end
  end

  // Previous questionable level; reset low, so a level already high after reset counts as a rise
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ques_curr_d <= 1'b0;
      ques_volt_d <= 1'b0;
    end else begin
      ques_curr_d <= ques_curr_i;
      ques_volt_d <= ques_volt_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_o <= '0;
    end else begin
      resp_o <= resp;
    end
  end

  // Status byte lives elsewhere; this pulse is its clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clear_stb_o <= 1'b0;
    end else begin
      clear_stb_o <= clear_w;
    end
  end

  sesl_err_queue u_err_queue (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .push_i      (err_i.valid),
    .push_code_i (err_i.err_code),
    .pop_i       (err_pop_i),
    .flush_i     (cmd_i.clear_status),
    .empty_o     (err_empty_o),
    .head_code_o (err_head_o)
  );

  assign flags_o     = flags;
  assign mask_o      = mask;
  assign esb_o       = |(flags & mask);
  assign opc_armed_o = (opc_state == SESL_OPC_ARMED);
endmodule : sesl_event_status
`default_nettype wire

// ===== logic/sesl_map.svh
// Field positions, class codes, reset values and queue sizes of the event status logic
`ifndef SESL_MAP_SVH
`define SESL_MAP_SVH
`define SESL_BIT_OPC       3'd0
`define SESL_BIT_QUE       3'd2
`define SESL_BIT_DDE       3'd3
`define SESL_BIT_EXE       3'd4
`define SESL_BIT_CME       3'd5
`define SESL_STB_ESB       3'd5
`define SESL_USED_MASK     8'h3d
`define SESL_MASK_RESET    8'h00
`define SESL_FLAGS_RESET   8'h00
`define SESL_CLASS_CMD     4'h1
`define SESL_CLASS_EXE     4'h2
`define SESL_CLASS_DEV     4'h3
`define SESL_CLASS_QUERY   4'h4
`define SESL_ERR_Q_DEPTH   4
`define SESL_ERR_Q_PTR_W   2
`endif

// ===== logic/sesl_pkg.sv
// Types shared by the event status logic
`default_nettype none
package sesl_pkg;
  typedef enum logic [1:0] {
    SESL_OPC_IDLE,
    SESL_OPC_ARMED
  } sesl_opc_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] err_class;
    logic [9:0] err_code;
  } sesl_err_s;

  typedef struct packed {
    logic       mask_wr;
    logic [7:0] mask_data;
    logic       mask_query;
    logic       flags_query;
    logic       clear_status;
    logic       opc_cmd;
  } sesl_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sesl_resp_s;
endpackage : sesl_pkg
`default_nettype wire

// ===== logic/sesl_err_queue.sv
// Small error queue: cleared as a whole by the clear-status command
`include "sesl_map.svh"
`default_nettype none
module sesl_err_queue (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Push and pop
  input  wire logic              push_i,
  input  wire logic [9:0]        push_code_i,
  input  wire logic              pop_i,
  input  wire logic              flush_i,
  // State
  output logic                   empty_o,
  output logic [9:0]             head_code_o
);
  import sesl_pkg::*;
  localparam int D = `SESL_ERR_Q_DEPTH;
  logic [9:0]                    mem [D];
  logic [`SESL_ERR_Q_PTR_W-1:0]  wr_ptr;
  logic [`SESL_ERR_Q_PTR_W-1:0]  rd_ptr;
  logic [`SESL_ERR_Q_PTR_W:0]    count;
  wire                           full_w  = (count == (`SESL_ERR_Q_PTR_W+1)'(D));
  wire                           do_push = push_i && !full_w && !flush_i;
  wire                           do_pop  = pop_i && (count != '0) && !flush_i;

  assign empty_o     = (count == '0);
  assign head_code_o = mem[rd_ptr];

  // Newest errors are dropped when full; the oldest are the ones worth reading
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (`SESL_ERR_Q_PTR_W+1)'(do_push) - (`SESL_ERR_Q_PTR_W+1)'(do_pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_push) mem[wr_ptr] <= push_code_i;
  end
endmodule : sesl_err_queue
`default_nettype wire

// ===== dv/sesl_parser_model.sv
// Command parser model issuing one-cycle commands and error reports
`default_nettype none
module sesl_parser_model
  import sesl_pkg::*;
(
  // Clock
  input  wire logic                sys_clk_i,
  // Toward the event logic
  output var sesl_pkg::sesl_cmd_s  cmd_o,
  output var sesl_pkg::sesl_err_s  err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_o = '0;
    err_o = '0;
  end
  // Never holds a pulse: a held bit would be taken twice
  task automatic issue(input sesl_cmd_s c, input sesl_err_s e);
    @(posedge sys_clk_i);
    cmd_o <= c;
    err_o <= e;
    @(posedge sys_clk_i);
    cmd_o <= '0;
    err_o <= '0;
  endtask : issue
endmodule : sesl_parser_model
`default_nettype wire

// ===== dv/sesl_event_status_sva.sv
// Port checks of the event status logic
`default_nettype none
module sesl_event_status_sva (
  // Clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 nrst_i,
  // Inputs watched
  input wire sesl_pkg::sesl_cmd_s  cmd_i,
  input wire sesl_pkg::sesl_err_s  err_i,
  input wire logic                 ops_idle_i,
  // Outputs watched
  input wire sesl_pkg::sesl_resp_s resp_o,
  input wire logic [7:0]           flags_o,
  input wire logic [7:0]           mask_o,
  input wire logic                 esb_o,
  input wire logic                 clear_stb_o,
  input wire logic                 err_empty_o,
  input wire logic                 opc_armed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_esb_summary: assert property (esb_o == |(flags_o & mask_o))
    else $error("summary bit wrong");
  a_unused_zero: assert property (flags_o[7:6] == 2'h0 && !flags_o[1])
    else $error("unused flag set");
  a_mask_write: assert property (cmd_i.mask_wr |=> mask_o == $past(cmd_i.mask_data))
    else $error("mask not stored");
  a_mask_query: assert property (cmd_i.mask_query && !cmd_i.flags_query
    |=> resp_o.valid && resp_o.data == $past(mask_o)) else $error("mask answer wrong");
  a_flags_read: assert property (cmd_i.flags_query
    |=> resp_o.valid && resp_o.data == $past(flags_o)) else $error("flags answer wrong");
  a_clear_keeps: assert property (cmd_i.clear_status && !cmd_i.mask_wr && !err_i.valid
    && !cmd_i.opc_cmd |=> $stable(mask_o) && clear_stb_o && err_empty_o && !opc_armed_o)
    else $error("clear status wrong");
  a_class_bit: assert property (err_i.valid && err_i.err_class inside {[4'h1:4'h4]}
    |=> flags_o[3'd6 - $past(err_i.err_class[2:0])]) else $error("class bit missing");
  a_opc_arm: assert property (cmd_i.opc_cmd && !opc_armed_o && !cmd_i.clear_status
    |=> opc_armed_o && !flags_o[0]) else $error("completion not armed");
  a_opc_done: assert property (opc_armed_o && ops_idle_i && !cmd_i.clear_status
    && !cmd_i.opc_cmd |=> flags_o[0] && !opc_armed_o) else $error("completion not set");
  a_flags_sticky: assert property (!cmd_i.flags_query && !cmd_i.clear_status
    && !cmd_i.opc_cmd |=> (flags_o & $past(flags_o)) == $past(flags_o))
    else $error("flag lost");
endmodule : sesl_event_status_sva
bind sesl_event_status sesl_event_status_sva chk (.*);
`default_nettype wire

// ===== dv/sesl_event_status_bench.sv
// Self-checking bench of the event status logic
`default_nettype none
module sesl_event_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sesl_pkg::*;
  localparam sesl_cmd_s CQM = 13'h008, CQF = 13'h004, CCL = 13'h002, COP = 13'h001;
  logic sys_clk_i, nrst_i, err_pop_i, curr_err_i, volt_err_i, ques_curr_i, ques_volt_i;
  logic ops_idle_i, esb, armed, empty, stb;
  logic [9:0] err_head;
  logic [7:0] flags, mask, exp;
  sesl_cmd_s cmd;
  sesl_err_s err;
  sesl_resp_s resp;
  int num_errors, n_checks, cyc;
  sesl_parser_model par (.sys_clk_i(sys_clk_i), .cmd_o(cmd), .err_o(err));
  sesl_event_status uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_i(cmd), .err_i(err),
    .err_pop_i(err_pop_i), .curr_err_i(curr_err_i), .volt_err_i(volt_err_i),
    .ques_curr_i(ques_curr_i), .ques_volt_i(ques_volt_i), .ops_idle_i(ops_idle_i),
    .resp_o(resp), .flags_o(flags), .mask_o(mask), .esb_o(esb), .clear_stb_o(stb),
    .err_empty_o(empty), .err_head_o(err_head), .opc_armed_o(armed));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic go(input sesl_cmd_s c, input sesl_err_s e);
    par.issue(c, e);
    #1;
  endtask : go
  task automatic s_mask();
    logic [7:0] pat [3];
    pat = '{8'hff, 8'h00, 8'h3c};
    foreach (pat[i]) begin
      go({1'b1, pat[i], 4'h0}, '0);
      go(CQM, '0);
      chk("mask_query", {resp.valid, resp.data, mask}, {1'b1, pat[i], pat[i]});
    end
  endtask : s_mask
  task automatic s_err();
    for (int c = 1; c <= 5; c++) begin
      go('0, {1'b1, 4'(c), 10'(c * 100)});
      exp = (c < 5) ? 8'h01 << (6 - c) : 8'h00;
      chk("class_flag", {esb, flags}, {|exp, exp});
      go(CQF, '0);
      chk("flags_read", {resp.data, flags}, {exp, 8'h00});
    end
    // Four reports fill the queue; the fifth is dropped, the oldest heads it
    chk("queue_head", {empty, err_head}, {1'b0, 10'd100});
    @(posedge sys_clk_i);
    err_pop_i <= 1'b1;
    @(posedge sys_clk_i);
    err_pop_i <= 1'b0;
    #1;
    chk("queue_pop", err_head, 10'd200);
  endtask : s_err
  task automatic s_fault();
    for (int k = 0; k < 2; k++) begin
      go(CQF, '0);
      @(posedge sys_clk_i);
      {curr_err_i, ques_curr_i} <= {2{k == 0}};
      {volt_err_i, ques_volt_i} <= {2{k == 1}};
      @(posedge sys_clk_i);
      {curr_err_i, ques_curr_i, volt_err_i, ques_volt_i} <= '0;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("dev_fault", flags, 8'h08);
    end
  endtask : s_fault
  task automatic s_opc();
    go(COP, '0);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("opc_wait", {armed, flags[0]}, 2'b10);
    @(posedge sys_clk_i);
    ops_idle_i <= 1'b1;
    @(posedge sys_clk_i);
    ops_idle_i <= 1'b0;
    #1;
    chk("opc_done", {armed, flags[0]}, 2'b01);
  endtask : s_opc
  task automatic s_clear();
    go(COP, '0);
    go('0, {1'b1, 4'h2, 10'd200});
    go(CCL, '0);
    chk("clear", {flags, armed, empty, mask}, {8'h00, 2'b01, 8'h3c});
    chk("clear_strobe", stb, 1'b1);
  endtask : s_clear
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // Ceiling well above the roughly 70 cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {nrst_i, err_pop_i, curr_err_i, volt_err_i, ques_curr_i, ques_volt_i, ops_idle_i} = '0;
    repeat (10) @(posedge sys_clk_i);
    chk("reset", {mask, flags, empty}, 17'h00001);
    nrst_i <= 1'b1;
    s_mask();
    s_err();
    s_fault();
    s_opc();
    s_clear();
    tally_and_finish();
  end
endmodule : sesl_event_status_bench
`default_nettype wire
